/* File: rtl/scan_acq_host.sv */
`timescale 1ns/1ns
`include "scan_host_params.svh"
// Summary of operation
// - Scan interval must cover whole sequence; host checks only its range, 2 to 65536, when enabled
// - Last entry of sequence carries end flag
// - Clear, write entries, then load memory
// - Fixed eight-write sample interval sequence
// - Value 65536 written as zero
// - Counter writes are sixteen-bit operations
// - Wide counts chain both counters, minimum two
// - Narrow count loading sequence
// - Wide low half minus one, reload zero
// - Wide high half adjusted, load and arm
// - Clear results then load first entry
module scan_acq_host
   import scan_host_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int ENTRY_W = 16,
   parameter int WR_GAP = `WR_GAP_DEFAULT
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic ent_we_in,
   input wire logic [$clog2(DEPTH)-1:0] ent_addr_in,
   input wire logic [ENTRY_W-1:0] ent_data_in,
   input wire logic [$clog2(DEPTH):0] n_entries_in,
   input wire logic go_in,
   input wire scan_host_pkg::timebase_e samp_tb_in,
   input wire logic [16:0] samp_int_in,
   input wire logic [31:0] count_in,
   input wire logic scan_int_en_in,
   input wire scan_host_pkg::timebase_e scan_tb_in,
   input wire logic [16:0] scan_int_in,
   input wire logic scan_div_in,
   input wire logic scan_en_in,
   output logic [4:0] dev_addr_out,
   output logic [15:0] dev_data_out,
   output logic dev_wr_out,
   output logic dev_word16_out,
   output logic busy_out,
   output logic done_out,
   output logic err_out
);
   import scan_host_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [7:0] GAP = 8'(WR_GAP);

   initial begin
      // Step counter needs four bits; entries are full device words
      if (WR_GAP < 1 || WR_GAP > 255 || DEPTH < 8 || ENTRY_W != 16) begin
         $error("scan_acq_host: unsupported parameter values");
      end
   end

   host_state_e st_r, st_nxt;
   logic [AW:0] step_r, step_nxt;
   logic [7:0] gap_r, gap_nxt;
   logic [AW-1:0] raddr_r, raddr_nxt;
   logic [4:0] addr_r, addr_nxt;
   logic [15:0] data_r, data_nxt;
   logic wr_r, wr_nxt, done_r, done_nxt, err_r, err_nxt;
   timebase_e stb_r, stb_nxt, ctb_r, ctb_nxt;
   logic [16:0] sint_r, sint_nxt, cint_r, cint_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [AW:0] nent_r, nent_nxt;
   logic [15:0] cmd1_r, cmd1_nxt;
   logic [ENTRY_W-1:0] ent_rdata;
   logic [20:0] op;
   logic wide, ok, last_step;
   logic [3:0] k;

   entry_store #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_store (
      .clk_sys_in(clk_sys_in),
      .we_in(ent_we_in),
      .waddr_in(ent_addr_in),
      .wdata_in(ent_data_in),
      .raddr_in(raddr_r),
      .rdata_out(ent_rdata)
   );

   function automatic logic [15:0] tb_word(input timebase_e sel);
      case (sel)
         TB_5MHZ: tb_word = `MODE_5MHZ;
         TB_1MHZ: tb_word = `MODE_1MHZ;
         TB_100KHZ: tb_word = `MODE_100KHZ;
         TB_10KHZ: tb_word = `MODE_10KHZ;
         TB_1KHZ: tb_word = `MODE_1KHZ;
         TB_100HZ: tb_word = `MODE_100HZ;
         default: tb_word = `MODE_EXT;
      endcase
   endfunction : tb_word

   function automatic logic ival_ok(input logic [16:0] v);
      ival_ok = (v >= `IVAL_MIN) && (v <= `IVAL_MAX);
   endfunction : ival_ok

   // interval counter sequence, value truncated for 65536
   function automatic logic [20:0] ival_op(input logic [3:0] i,
         input logic [15:0] c_mode, input logic [15:0] c_sel,
         input logic [15:0] c_load, input logic [15:0] c_step,
         input logic [15:0] c_arm, input logic [15:0] mode,
         input logic [16:0] v);
      case (i)
         4'h0: ival_op = {`OFS_CTR_CMD, c_mode};
         4'h1: ival_op = {`OFS_CTR_DATA, mode};
         4'h2: ival_op = {`OFS_CTR_CMD, c_sel};
         4'h3: ival_op = {`OFS_CTR_DATA, `PRELOAD_TWO};
         4'h4: ival_op = {`OFS_CTR_CMD, c_load};
         4'h5: ival_op = {`OFS_CTR_CMD, c_step};
         4'h6: ival_op = {`OFS_CTR_DATA, v[15:0]};
         default: ival_op = {`OFS_CTR_CMD, c_arm};
      endcase
   endfunction : ival_op

   function automatic logic [20:0] cnt_op(input logic [3:0] i,
         input logic w, input logic [31:0] c);
      logic [15:0] lo_m1, hi_adj;
      lo_m1 = (c[15:0] == 16'h0000) ? 16'hffff : c[15:0] - 16'h0001;
      hi_adj = (c[15:1] == 15'h0000) ? c[31:16] : c[31:16] + 16'h0001;
      case (i)
         4'h0: cnt_op = {`OFS_CTR_CMD, `LO_SEL_MODE};
         4'h1: cnt_op = {`OFS_CTR_DATA, `LO_MODE};
         4'h2: cnt_op = {`OFS_CTR_CMD, `LO_SEL_LOAD};
         4'h3: cnt_op = {`OFS_CTR_DATA, w ? lo_m1 : c[15:0]};
         4'h4: cnt_op = {`OFS_CTR_CMD, `LO_LOAD};
         4'h5: cnt_op = w ? {`OFS_CTR_DATA, `ZERO_WORD}
                          : {`OFS_CTR_CMD, `LO_DECR};
         4'h6: cnt_op = {`OFS_CTR_CMD, `LO_ARM};
         4'h7: cnt_op = {`OFS_CTR_CMD, `HI_SEL_MODE};
         4'h8: cnt_op = {`OFS_CTR_DATA, `HI_MODE};
         4'h9: cnt_op = {`OFS_CTR_CMD, `HI_SEL_LOAD};
         4'ha: cnt_op = {`OFS_CTR_DATA, hi_adj};
         default: cnt_op = {`OFS_CTR_CMD, `HI_LOAD_ARM};
      endcase
   endfunction : cnt_op

   assign wide = cnt_r > `CNT_NARROW_MAX;
   assign k = step_r[3:0];
   assign ok = ival_ok(samp_int_in) && (count_in >= `CNT_MIN)
      && (!scan_int_en_in || ival_ok(scan_int_in))
      && (n_entries_in != '0) && (n_entries_in <= (AW+1)'(DEPTH));

   always_comb begin
      op = {`OFS_MEM_CLR, `ZERO_WORD};
      last_step = 1'b1;
      case (st_r)
         ST_MEMWR: begin
            // entries in order, then memory load
            last_step = (step_r == nent_r);
            if (last_step) begin
               op = {`OFS_MEM_LD, `ZERO_WORD};
            end else if (step_r == nent_r - 1'b1) begin
               // final entry always carries the end flag
               op = {`OFS_MEM_WR, 1'b1, ent_rdata[14:0]};
            end else begin
               op = {`OFS_MEM_WR, ent_rdata[15:0]};
            end
         end
         ST_SAMP: begin
            op = ival_op(k, `SAMP_SEL_MODE, `SAMP_SEL_LOAD, `SAMP_LOAD,
               `SAMP_STEP, `SAMP_ARM, tb_word(stb_r), sint_r);
            last_step = (k == `IVAL_LAST);
         end
         ST_CNT: begin
            op = cnt_op(k, wide, cnt_r);
            last_step = (k == (wide ? `CNT_LAST_WIDE : `CNT_LAST_NARROW));
         end
         ST_SCAN: begin
            op = ival_op(k, `SCAN_SEL_MODE, `SCAN_SEL_LOAD, `SCAN_LOAD,
               `SCAN_STEP, `SCAN_ARM, tb_word(ctb_r), cint_r);
            last_step = (k == `IVAL_LAST);
         end
         ST_TAIL: begin
            // clear results, select first entry, enable
            case (k)
               4'h0: op = {`OFS_CONV_CLR, `ZERO_WORD};
               4'h1: op = {`OFS_MEM_LD, `ZERO_WORD};
               default: op = {`OFS_CMD1, cmd1_r};
            endcase
            last_step = (k == `TAIL_LAST);
         end
         default: ;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      step_nxt = step_r;
      gap_nxt = gap_r;
      raddr_nxt = raddr_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      wr_nxt = 1'b0;
      done_nxt = 1'b0;
      err_nxt = err_r;
      stb_nxt = stb_r;
      ctb_nxt = ctb_r;
      sint_nxt = sint_r;
      cint_nxt = cint_r;
      cnt_nxt = cnt_r;
      nent_nxt = nent_r;
      cmd1_nxt = cmd1_r;
      if (st_r == ST_IDLE) begin
         if (go_in) begin
            err_nxt = !ok;
            if (ok) begin
               st_nxt = ST_MEMCLR;
               raddr_nxt = '0;
               stb_nxt = samp_tb_in;
               ctb_nxt = scan_tb_in;
               sint_nxt = samp_int_in;
               cint_nxt = scan_int_in;
               cnt_nxt = count_in;
               nent_nxt = n_entries_in;
               cmd1_nxt = `CMD1_RESET;
               // control bits for the final enable
               cmd1_nxt[`CMD1_SCAN_EN] = scan_en_in;
               cmd1_nxt[`CMD1_SCAN_DIV] = scan_div_in;
               cmd1_nxt[`CMD1_SCAN_INT] = scan_int_en_in;
               cmd1_nxt[`CMD1_WIDTH] = count_in > `CNT_NARROW_MAX;
               cmd1_nxt[`CMD1_ACQ_EN] = 1'b1;
            end
         end
      end else if (gap_r != 8'h00) begin
         gap_nxt = gap_r - 8'h01;
      end else begin
         wr_nxt = 1'b1;
         addr_nxt = op[20:16];
         data_nxt = op[15:0];
         gap_nxt = GAP;
         step_nxt = step_r + 1'b1;
         if (st_r == ST_MEMWR) begin
            raddr_nxt = AW'(step_r + 1'b1);
         end
         if (last_step) begin
            step_nxt = '0;
            case (st_r)
               ST_MEMCLR: st_nxt = ST_MEMWR;
               ST_MEMWR: st_nxt = ST_SAMP;
               ST_SAMP: st_nxt = ST_CNT;
               ST_CNT: st_nxt = cmd1_r[`CMD1_SCAN_INT] ? ST_SCAN : ST_TAIL;
               ST_SCAN: st_nxt = ST_TAIL;
               ST_TAIL: begin
                  st_nxt = ST_IDLE;
                  gap_nxt = 8'h00;
                  done_nxt = 1'b1;
               end
               default: st_nxt = ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         // pointer to entry zero, control bits cleared
         st_r <= ST_IDLE;
         step_r <= '0;
         gap_r <= 8'h00;
         raddr_r <= '0;
         addr_r <= 5'h00;
         data_r <= 16'h0000;
         wr_r <= 1'b0;
         done_r <= 1'b0;
         err_r <= 1'b0;
         stb_r <= TB_5MHZ;
         ctb_r <= TB_5MHZ;
         sint_r <= 17'h00000;
         cint_r <= 17'h00000;
         cnt_r <= 32'h0000_0000;
         nent_r <= '0;
         cmd1_r <= `CMD1_RESET;
      end else begin
         st_r <= st_nxt;
         step_r <= step_nxt;
         gap_r <= gap_nxt;
         raddr_r <= raddr_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         wr_r <= wr_nxt;
         done_r <= done_nxt;
         err_r <= err_nxt;
         stb_r <= stb_nxt;
         ctb_r <= ctb_nxt;
         sint_r <= sint_nxt;
         cint_r <= cint_nxt;
         cnt_r <= cnt_nxt;
         nent_r <= nent_nxt;
         cmd1_r <= cmd1_nxt;
      end
   end

   assign dev_addr_out = addr_r;
   assign dev_data_out = data_r;
   assign dev_wr_out = wr_r;
   assign dev_word16_out = wr_r;
   assign busy_out = (st_r != ST_IDLE);
   assign done_out = done_r;
   assign err_out = err_r;
endmodule : scan_acq_host

/* File: rtl/scan_host_params.svh */
`ifndef SCAN_HOST_PARAMS_SVH
`define SCAN_HOST_PARAMS_SVH

// Device word addresses of the writable ports
`define OFS_CMD1 5'h00
`define OFS_MEM_CLR 5'h02
`define OFS_MEM_WR 5'h04
`define OFS_MEM_LD 5'h06
`define OFS_CONV_CLR 5'h08
`define OFS_CTR_DATA 5'h0c
`define OFS_CTR_CMD 5'h0e

// Command register 1 bit positions
`define CMD1_SCAN_EN 0
`define CMD1_SCAN_INT 1
`define CMD1_SCAN_DIV 2
`define CMD1_WIDTH 3
`define CMD1_ACQ_EN 4
`define CMD1_RESET 16'h0000

// Sample-interval counter commands
`define SAMP_SEL_MODE 16'hff03
`define SAMP_SEL_LOAD 16'hff0b
`define SAMP_LOAD 16'hff44
`define SAMP_STEP 16'hfff3
`define SAMP_ARM 16'hff24

// Scan-interval counter commands
`define SCAN_SEL_MODE 16'hff02
`define SCAN_SEL_LOAD 16'hff0a
`define SCAN_LOAD 16'hff42
`define SCAN_STEP 16'hfff2
`define SCAN_ARM 16'hff22

// Sample counter commands and mode words
`define LO_SEL_MODE 16'hff04
`define LO_MODE 16'h1025
`define LO_SEL_LOAD 16'hff0c
`define LO_LOAD 16'hff48
`define LO_DECR 16'hfff4
`define LO_ARM 16'hff28
`define HI_SEL_MODE 16'hff05
`define HI_MODE 16'h0025
`define HI_SEL_LOAD 16'hff0d
`define HI_LOAD_ARM 16'hff70

// Timebase mode words
`define MODE_5MHZ 16'h8225
`define MODE_1MHZ 16'h8b25
`define MODE_100KHZ 16'h8c25
`define MODE_10KHZ 16'h8d25
`define MODE_1KHZ 16'h8e25
`define MODE_100HZ 16'h8f25
`define MODE_EXT 16'h8525

`define PRELOAD_TWO 16'h0002
`define ZERO_WORD 16'h0000
`define IVAL_MIN 17'h00002
`define IVAL_MAX 17'h10000
`define CNT_MIN 32'h0000_0002
`define CNT_NARROW_MAX 32'h0001_0000
`define IVAL_LAST 4'h7
`define CNT_LAST_NARROW 4'h6
`define CNT_LAST_WIDE 4'hb
`define TAIL_LAST 4'h2
`define WR_GAP_DEFAULT 2

`endif

/* File: rtl/scan_host_pkg.sv */
package scan_host_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_MEMCLR = 7'b0000010,
      ST_MEMWR = 7'b0000100,
      ST_SAMP = 7'b0001000,
      ST_CNT = 7'b0010000,
      ST_SCAN = 7'b0100000,
      ST_TAIL = 7'b1000000
   } host_state_e;

   typedef enum logic [2:0] {
      TB_5MHZ = 3'h0,
      TB_1MHZ = 3'h1,
      TB_100KHZ = 3'h2,
      TB_10KHZ = 3'h3,
      TB_1KHZ = 3'h4,
      TB_100HZ = 3'h5,
      TB_EXT = 3'h6
   } timebase_e;
endpackage : scan_host_pkg

/* File: rtl/entry_store.sv */
`timescale 1ns/1ns
module entry_store #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_in,
   input wire logic we_in,
   input wire logic [$clog2(DEPTH)-1:0] waddr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   input wire logic [$clog2(DEPTH)-1:0] raddr_in,
   output logic [WIDTH-1:0] rdata_out
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_r;

   initial begin
      if (DEPTH < 2 || WIDTH < 2) begin
         $error("entry_store: DEPTH and WIDTH must be at least 2");
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_r <= mem[raddr_in];
   end

   assign rdata_out = rdata_r;
endmodule : entry_store

/* File: verification/scan_acq_host_checker.sv */
`timescale 1ns/1ns
module scan_acq_host_checker #(
   parameter int WR_GAP = 2
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [4:0] dev_addr_out,
   input wire logic [15:0] dev_data_out,
   input wire logic dev_wr_out,
   input wire logic dev_word16_out,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic err_out
);
   logic [7:0] gap_r;
   logic [7:0] gap_nxt;
   logic seen_r;
   logic seen_nxt;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   // Cycles since the last strobe, and whether this run has had one
   always_comb begin
      gap_nxt = (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
      if (dev_wr_out) begin
         gap_nxt = 8'h00;
      end
      seen_nxt = done_out ? 1'b0 : (dev_wr_out | seen_r);
   end
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         gap_r <= 8'h00;
         seen_r <= 1'b0;
      end else begin
         gap_r <= gap_nxt;
         seen_r <= seen_nxt;
      end
   end
   a_word_with_strobe: assert property (dev_word16_out == dev_wr_out)
      else $error("width flag differs from strobe");
   a_first_clears_mem: assert property ($rose(busy_out) |=> dev_wr_out
      && dev_addr_out == 5'h02 && dev_data_out == 16'h0000)
      else $error("first write is not the memory clear");
   a_strobe_spacing: assert property (dev_wr_out && seen_r
      |-> gap_r == WR_GAP[7:0])
      else $error("strobe spacing wrong");
   a_done_last_cmd: assert property (done_out
      |-> dev_wr_out && dev_addr_out == 5'h00)
      else $error("done not on control word write");
   a_clear_then_load: assert property (done_out
      |-> $past(dev_addr_out, 3) == 5'h06 && $past(dev_addr_out, 6) == 5'h08)
      else $error("result clear and load not just before control");
   a_reset_quiet: assert property ($fell(srst_in)
      |-> !busy_out && !dev_wr_out && !done_out && !err_out)
      else $error("outputs active after reset");
   a_err_blocks_write: assert property (err_out |-> !dev_wr_out && !busy_out)
      else $error("write despite refused setup");
   a_addr_holds: assert property (!dev_wr_out && !$past(srst_in)
      |-> $stable(dev_addr_out) && $stable(dev_data_out))
      else $error("address or data moved without strobe");
   a_run_bounded: assert property ($rose(busy_out) |-> ##[1:600] done_out)
      else $error("run did not finish");
endmodule : scan_acq_host_checker

/* File: verification/scan_dev_model.sv */
`timescale 1ns/1ns
module scan_dev_model (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [4:0] dev_addr_in,
   input wire logic [15:0] dev_data_in,
   input wire logic dev_wr_in,
   input wire logic dev_word16_in
);
   logic [20:0] log_q[$];
   logic [15:0] mem_r [16];
   logic [3:0] wptr_r = 4'h0;
   logic [3:0] rptr_r = 4'h0;
   logic [15:0] cmd1_r = 16'h0000;
   always @(posedge clk_sys_in) begin
      if (srst_in) begin
         rptr_r <= 4'h0;
         cmd1_r <= 16'h0000;
      end else if (dev_wr_in) begin
         log_q.push_back(dev_word16_in ? {dev_addr_in, dev_data_in} : 'x);
         case (dev_addr_in)
            // clear, fill in order, flag kept
            5'h02: wptr_r <= 4'h0;
            5'h04: begin
               mem_r[wptr_r] <= dev_data_in;
               wptr_r <= wptr_r + 4'h1;
            end
            5'h06: rptr_r <= 4'h0;
            5'h00: cmd1_r <= dev_data_in;
            default: ;
         endcase
      end
   end
endmodule : scan_dev_model

/* File: verification/scan_acq_host_test.sv */
`timescale 1ns/1ns
module scan_acq_host_test;
   import scan_host_pkg::*;
   typedef struct {
      int n; timebase_e stb; logic [16:0] si; logic [31:0] cnt;
      logic sie; timebase_e ctb; logic [16:0] ci; logic dv; logic en;
      logic [15:0] lo_w; logic [15:0] hi_w;
   } row_s;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic ent_we_in = 1'b0;
   logic [3:0] ent_addr_in = 4'h0;
   logic [15:0] ent_data_in = 16'h0000;
   logic [4:0] n_entries_in = 5'h01;
   logic go_in = 1'b0;
   timebase_e samp_tb_in = TB_5MHZ;
   timebase_e scan_tb_in = TB_5MHZ;
   logic [16:0] samp_int_in = 17'h00002;
   logic [16:0] scan_int_in = 17'h00002;
   logic [31:0] count_in = 32'h2;
   logic scan_int_en_in = 1'b0;
   logic scan_div_in = 1'b0;
   logic scan_en_in = 1'b0;
   logic [4:0] dev_addr_out;
   logic [15:0] dev_data_out;
   logic dev_wr_out, dev_word16_out, busy_out, done_out, err_out;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   logic [20:0] exp_q[$];
   logic [15:0] mode_w [7] = '{16'h8225, 16'h8b25, 16'h8c25, 16'h8d25,
      16'h8e25, 16'h8f25, 16'h8525};
   row_s rows [7] = '{
      '{4, TB_5MHZ, 17'h2, 32'h2, 1, TB_EXT, 17'h10000, 0, 1, 16'h2, 16'h0},
      '{2, TB_1MHZ, 17'h10000, 32'h10000, 0, TB_5MHZ, 17'h2, 1, 1, 16'h0, 16'h0},
      '{1, TB_100KHZ, 17'h64, 32'h20000, 1, TB_100HZ, 17'h1388, 1, 0,
         16'hffff, 16'h2},
      '{3, TB_10KHZ, 17'hffff, 32'h30001, 0, TB_5MHZ, 17'h2, 0, 1, 16'h0, 16'h3},
      '{16, TB_1KHZ, 17'h7, 32'h10005, 1, TB_1MHZ, 17'hffff, 0, 1, 16'h4, 16'h2},
      '{2, TB_100HZ, 17'h3, 32'h10001, 1, TB_10KHZ, 17'h40, 1, 1, 16'h0, 16'h1},
      '{3, TB_EXT, 17'h5, 32'hffff, 1, TB_1KHZ, 17'h30, 0, 1, 16'hffff, 16'h0}};
   scan_acq_host uut (.clk_sys_in, .srst_in, .ent_we_in, .ent_addr_in,
      .ent_data_in, .n_entries_in, .go_in, .samp_tb_in, .samp_int_in,
      .count_in, .scan_int_en_in, .scan_tb_in, .scan_int_in, .scan_div_in,
      .scan_en_in, .dev_addr_out, .dev_data_out, .dev_wr_out,
      .dev_word16_out, .busy_out, .done_out, .err_out);
   scan_dev_model dev (.clk_sys_in, .srst_in, .dev_addr_in(dev_addr_out),
      .dev_data_in(dev_data_out), .dev_wr_in(dev_wr_out),
      .dev_word16_in(dev_word16_out));
   initial begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   function automatic logic [15:0] ent(input int i);
      return (i == 1 ? 16'h8000 : 16'h0000) | (16'h0100 + 16'(i));
   endfunction : ent
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   task automatic pc(input logic [15:0] v);
      exp_q.push_back({5'h0e, v});
   endtask : pc
   task automatic pd(input logic [15:0] v);
      exp_q.push_back({5'h0c, v});
   endtask : pd
   task automatic build(input row_s r);
      logic wide;
      wide = r.cnt > 32'h10000;
      exp_q.delete();
      exp_q.push_back({5'h02, 16'h0000});
      for (int i = 0; i < r.n; i++) begin
         exp_q.push_back({5'h04, ent(i) | (i == r.n - 1 ? 16'h8000 : 16'h0)});
      end
      exp_q.push_back({5'h06, 16'h0000});
      pc(16'hff03); pd(mode_w[r.stb]); pc(16'hff0b); pd(16'h0002);
      pc(16'hff44); pc(16'hfff3); pd(r.si[15:0]); pc(16'hff24);
      pc(16'hff04); pd(16'h1025); pc(16'hff0c); pd(r.lo_w); pc(16'hff48);
      if (wide) begin
         pd(16'h0000); pc(16'hff28); pc(16'hff05); pd(16'h0025);
         pc(16'hff0d); pd(r.hi_w); pc(16'hff70);
      end else begin
         pc(16'hfff4); pc(16'hff28);
      end
      if (r.sie) begin
         pc(16'hff02); pd(mode_w[r.ctb]); pc(16'hff0a); pd(16'h0002);
         pc(16'hff42); pc(16'hfff2); pd(r.ci[15:0]); pc(16'hff22);
      end
      exp_q.push_back({5'h08, 16'h0000});
      exp_q.push_back({5'h06, 16'h0000});
      exp_q.push_back({5'h00, {11'h0, 1'b1, wide, r.dv, r.sie, r.en}});
   endtask : build
   task automatic apply(input row_s r);
      n_entries_in = 5'(r.n);
      samp_tb_in = r.stb;
      samp_int_in = r.si;
      count_in = r.cnt;
      scan_int_en_in = r.sie;
      scan_tb_in = r.ctb;
      scan_int_in = r.ci;
      scan_div_in = r.dv;
      scan_en_in = r.en;
      go_in = 1'b1;
   endtask : apply
   task automatic run(input row_s r, input bit dup);
      int base;
      int k;
      base = dev.log_q.size();
      build(r);
      apply(r);
      k = 0;
      do begin
         @(negedge clk_sys_in);
         go_in = dup && k == 12;
         k++;
      end while (done_out !== 1'b1 && k < 900);
      @(negedge clk_sys_in);
      check(busy_out, 1'b0);
      check(dev.log_q.size() - base, exp_q.size());
      foreach (exp_q[i]) check(dev.log_q[base + i], exp_q[i]);
      check(dev.mem_r[r.n - 1][15], 1'b1);
      check(dev.cmd1_r, exp_q[$][15:0]);
   endtask : run
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (2) @(negedge clk_sys_in);
      srst_in = 1'b0;
      for (int i = 0; i < 16; i++) begin
         ent_we_in = 1'b1;
         ent_addr_in = 4'(i);
         ent_data_in = ent(i);
         @(negedge clk_sys_in);
      end
      ent_we_in = 1'b0;
      foreach (rows[i]) run(rows[i], 1'b0);
      // Second start while busy must change nothing
      run(rows[4], 1'b1);
      // A count of one is refused without any write
      apply('{2, TB_1MHZ, 17'h2, 32'h1, 0, TB_5MHZ, 17'h2, 0, 1, 16'h0, 16'h0});
      @(negedge clk_sys_in);
      go_in = 1'b0;
      @(negedge clk_sys_in);
      check(err_out, 1'b1);
      check(busy_out, 1'b0);
      run(rows[0], 1'b0);
      check(err_out, 1'b0);
      // Reset in mid-run, then a clean restart
      apply(rows[3]);
      @(negedge clk_sys_in);
      go_in = 1'b0;
      repeat (30) @(negedge clk_sys_in);
      srst_in = 1'b1;
      @(negedge clk_sys_in);
      srst_in = 1'b0;
      check(busy_out, 1'b0);
      check(dev.cmd1_r, 16'h0000);
      run(rows[1], 1'b0);
      wrap_up();
   end
endmodule : scan_acq_host_test
bind scan_acq_host scan_acq_host_checker #(.WR_GAP(WR_GAP)) chk (.clk_sys_in,
   .srst_in, .dev_addr_out, .dev_data_out, .dev_wr_out, .dev_word16_out,
   .busy_out, .done_out, .err_out);
